// ===== hw/pll_cfg_pkg.sv
/*
 * Shared definitions for the synthesizer analog-enable and charge-pump register bank:
 * field layouts, word offsets, reset values and serial frame sizes.
 * Assumes a 24-bit register word and a 6-bit word address in the serial frame.
 */
package pll_cfg_pkg;
    // ==========================================================================
    // Register offsets, word indices on the serial port
    // ==========================================================================
    localparam logic [5:0] ANALOG_OFFSET  = 6'h08;
    localparam logic [5:0] PUMP_OFFSET    = 6'h09;
    localparam logic [5:0] TRIGGER_OFFSET = 6'h0a;

    // ==========================================================================
    // Field layouts
    // ==========================================================================
    typedef struct packed {
        logic [1:0] spare;                     // Bits 23:22.
        logic       high_freq_reference;       // Bit 21.
        logic       reserved20;
        logic       divide_by_two_on;          // Bit 19.
        logic       reserved18;
        logic [2:0] resync_bias;               // Bits 17:15.
        logic [2:0] rf_buffer_bias;            // Bits 14:12.
        logic       pump_opamp_on;             // Bit 11.
        logic       vco_prescaler_bias_on;     // Bit 10.
        logic       prescaler_clock_on;        // Bit 9.
        logic       reserved8;
        logic       divider_clock_to_logic_on; // Bit 7.
        logic       reserved6;
        logic       output_pad_enable;         // Bit 5.
        logic       vco_buffer_on;
        logic       reference_buffer_on;
        logic       phase_detector_on;
        logic       pump_on;
        logic       bias_reference_on;         // Bit 0.
    } analog_en_s;

    typedef struct packed {
        logic       high_gain_pump_mode;       // Bit 23.
        logic       offset_down;               // Bit 22.
        logic       offset_up;                 // Bit 21.
        logic [6:0] offset_magnitude;          // Bits 20:14, 5 uA per step.
        logic [6:0] pump_up_gain;              // Bits 13:7, 20 uA per step.
        logic [6:0] pump_down_gain;            // Bits 6:0, 20 uA per step.
    } pump_s;

    // ==========================================================================
    // Reset values and serial frame
    // ==========================================================================
    localparam logic [23:0] ANALOG_RESET  = 24'hc1beff;
    localparam logic [23:0] PUMP_RESET    = 24'h40050a;
    localparam logic [23:0] TRIGGER_RESET = 24'h002205;
    localparam logic [5:0]  ADDR_DONE     = 6'h07;  // Bits before the data field.
    localparam logic [5:0]  FRAME_BITS    = 6'h1f;  // Read flag, address, data.
endpackage : pll_cfg_pkg

// ===== hw/pll_cfg_regs.sv
/*
 * Register bank for the analog enables, charge-pump settings and auxiliary serial
 * trigger word, with its serial access port and the lock/readback pad control.
 * Assumes the serial pins and the general-purpose output controls come from outside
 * the CLOCK domain; all of them pass a two-stage synchroniser here.
 */
module pll_cfg_regs (
    input  wire logic                    CLOCK,
    input  wire logic                    RST,
    input  wire logic                    CE,
    input  wire logic                    SERIAL_SELECT,
    input  wire logic                    SERIAL_CLOCK,
    input  wire logic                    SERIAL_DATA_IN,
    input  wire logic                    PAD_ALWAYS_ON,
    input  wire logic                    READBACK_SELECT,
    input  wire logic                    LOCK_STATE,
    output pll_cfg_pkg::analog_en_s      ANALOG_ENABLES,
    output pll_cfg_pkg::pump_s           PUMP_SETTINGS,
    output logic [23:0]                  AUX_TRIGGER,
    output logic                         LOCK_READBACK_PIN_OUT,
    output logic                         LOCK_READBACK_PIN_OE
);
    // ==========================================================================
    // Input synchronisers
    // ==========================================================================
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic       sck_prev_reg;
    logic       sel_prev_reg;
    logic       sel;
    logic       sck;
    logic       sdi;
    logic       always_on;
    logic       rb_select;
    logic       lock_state;

    // Only the second stage is read, so a metastable first stage never fans out.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            sync1_reg    <= 6'h00;
            sync2_reg    <= 6'h00;
            sck_prev_reg <= 1'b0;
            sel_prev_reg <= 1'b0;
        end else if (CE) begin
            sync1_reg    <= {SERIAL_SELECT, SERIAL_CLOCK, SERIAL_DATA_IN,
                             PAD_ALWAYS_ON, READBACK_SELECT, LOCK_STATE};
            sync2_reg    <= sync1_reg;
            sck_prev_reg <= sync2_reg[4];
            sel_prev_reg <= sync2_reg[5];
        end
    end

    assign {sel, sck, sdi, always_on, rb_select, lock_state} = sync2_reg;

    // ==========================================================================
    // Serial frame engine
    // ==========================================================================
    logic [5:0]  cnt_reg;
    logic [5:0]  cnt_next;
    logic [29:0] shift_reg;
    logic [29:0] shift_next;
    logic [23:0] out_reg;
    logic [23:0] out_next;
    logic        sdo_reg;
    logic        sdo_next;
    logic        rise;
    logic        fall;
    logic        wr_fire;
    logic        reading;
    logic [5:0]  addr_now;
    logic [23:0] read_word;
    logic        rd_flag_reg;
    logic        rd_flag_next;

    assign rise     = sel && sck && !sck_prev_reg;
    assign fall     = sel && !sck && sck_prev_reg;
    assign addr_now = {shift_reg[4:0], sdi};
    // The read flag falls out of the 30-bit shifter, so it is held on its own.
    assign reading  = sel && rd_flag_reg && (cnt_reg >= pll_cfg_pkg::ADDR_DONE);
    // A write commits when select drops after a full frame with the read flag low.
    assign wr_fire  = !sel && sel_prev_reg && (cnt_reg == pll_cfg_pkg::FRAME_BITS)
                      && !rd_flag_reg;

    // Readback returns every stored bit, spare and reserved ones included.
    always_comb begin
        case (addr_now)
            pll_cfg_pkg::ANALOG_OFFSET:  read_word = ANALOG_ENABLES;
            pll_cfg_pkg::PUMP_OFFSET:    read_word = PUMP_SETTINGS;
            pll_cfg_pkg::TRIGGER_OFFSET: read_word = AUX_TRIGGER;
            default:                     read_word = 24'h000000;
        endcase
    end

    // Bits enter on a rising serial clock; readback bits change on the falling one.
    always_comb begin
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        out_next   = out_reg;
        sdo_next   = sdo_reg;
        rd_flag_next = rd_flag_reg;
        if (!sel && !wr_fire) begin
            cnt_next = 6'h00;
        end else if (rise && cnt_reg != pll_cfg_pkg::FRAME_BITS) begin
            cnt_next   = cnt_reg + 6'h01;
            shift_next = {shift_reg[28:0], sdi};
            // The first bit of every frame is the read flag.
            if (cnt_reg == 6'h00) begin
                rd_flag_next = sdi;
            end
            if (cnt_reg == pll_cfg_pkg::ADDR_DONE - 6'h01) begin
                out_next = read_word;
            end
        end else if (fall && reading) begin
            sdo_next = out_reg[23];
            out_next = {out_reg[22:0], 1'b0};
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            cnt_reg     <= 6'h00;
            shift_reg   <= 30'h00000000;
            out_reg     <= 24'h000000;
            sdo_reg     <= 1'b0;
            rd_flag_reg <= 1'b0;
        end else if (CE) begin
            cnt_reg     <= cnt_next;
            shift_reg   <= shift_next;
            out_reg     <= out_next;
            sdo_reg     <= sdo_next;
            rd_flag_reg <= rd_flag_next;
        end
    end

    // ==========================================================================
    // Configuration registers
    // ==========================================================================
    logic [5:0]  wr_addr;
    logic [23:0] wr_data;
    logic [23:0] analog_next;
    logic [23:0] pump_next;
    logic [23:0] trig_next;

    assign wr_addr = shift_reg[29:24];
    assign wr_data = shift_reg[23:0];

    // Fields hold until a full write frame lands on their own offset.
    always_comb begin
        analog_next = ANALOG_ENABLES;
        pump_next   = PUMP_SETTINGS;
        trig_next   = AUX_TRIGGER;
        if (wr_fire) begin
            case (wr_addr)
                pll_cfg_pkg::ANALOG_OFFSET:  analog_next = wr_data;
                pll_cfg_pkg::PUMP_OFFSET:    pump_next   = wr_data;
                pll_cfg_pkg::TRIGGER_OFFSET: trig_next   = wr_data;
                default:                     trig_next   = AUX_TRIGGER;
            endcase
        end
    end

    // Reset values put every analog block on but divide-by-two and the high-frequency reference, pump gains at ten, down offset on.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ANALOG_ENABLES <= pll_cfg_pkg::ANALOG_RESET;
            PUMP_SETTINGS  <= pll_cfg_pkg::PUMP_RESET;
            AUX_TRIGGER    <= pll_cfg_pkg::TRIGGER_RESET;
        end else if (CE) begin
            ANALOG_ENABLES <= analog_next;
            PUMP_SETTINGS  <= pump_next;
            AUX_TRIGGER    <= trig_next;
        end
    end

    // ==========================================================================
    // Lock/readback pad
    // ==========================================================================
    logic pad_oe_next;
    logic pad_out_next;

    // Always-on mode shows the lock state; otherwise only readback
    // drives the pin, so the pad stays quiet between frames and shares the wire.
    always_comb begin
        pad_oe_next  = 1'b0;
        pad_out_next = 1'b0;
        if (ANALOG_ENABLES.output_pad_enable) begin
            if (always_on) begin
                pad_oe_next  = 1'b1;
                pad_out_next = lock_state;
            end else if (!rb_select && reading) begin
                pad_oe_next  = 1'b1;
                pad_out_next = sdo_reg;
            end
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            LOCK_READBACK_PIN_OE  <= 1'b0;
            LOCK_READBACK_PIN_OUT <= 1'b0;
        end else if (CE) begin
            LOCK_READBACK_PIN_OE  <= pad_oe_next;
            LOCK_READBACK_PIN_OUT <= pad_out_next;
        end
    end

    // ==========================================================================
    // Assertions
    // ==========================================================================
    AST_PAD_OFF: assert property (@(posedge CLOCK) disable iff (RST)
        CE && !ANALOG_ENABLES.output_pad_enable |=> !LOCK_READBACK_PIN_OE)
        else $error("Pad driven while its enable is low.");

    AST_PAD_ALWAYS: assert property (@(posedge CLOCK) disable iff (RST)
        CE && ANALOG_ENABLES.output_pad_enable && always_on
        |=> LOCK_READBACK_PIN_OE && LOCK_READBACK_PIN_OUT == $past(lock_state))
        else $error("Pad not driven with lock state in always-on mode.");

    AST_PAD_READ: assert property (@(posedge CLOCK) disable iff (RST)
        CE && ANALOG_ENABLES.output_pad_enable && !always_on
        |=> LOCK_READBACK_PIN_OE == $past(!rb_select && reading))
        else $error("Readback drive does not follow select and frame.");

    AST_WRITE_ANALOG: assert property (@(posedge CLOCK) disable iff (RST)
        CE && wr_fire && wr_addr == pll_cfg_pkg::ANALOG_OFFSET
        |=> ANALOG_ENABLES == $past(wr_data))
        else $error("Analog enable write lost.");

    AST_WRITE_PUMP: assert property (@(posedge CLOCK) disable iff (RST)
        CE && wr_fire && wr_addr == pll_cfg_pkg::PUMP_OFFSET
        |=> PUMP_SETTINGS == $past(wr_data))
        else $error("Pump settings write lost.");

    AST_WRITE_TRIG: assert property (@(posedge CLOCK) disable iff (RST)
        CE && wr_fire && wr_addr == pll_cfg_pkg::TRIGGER_OFFSET
        |=> AUX_TRIGGER == $past(wr_data))
        else $error("Trigger word write lost.");

    AST_HOLD: assert property (@(posedge CLOCK) disable iff (RST)
        !(CE && wr_fire) |=> $stable(ANALOG_ENABLES) && $stable(PUMP_SETTINGS)
        && $stable(AUX_TRIGGER))
        else $error("Register changed without a write.");

    AST_RESET_VALUES: assert property (@(posedge CLOCK)
        $fell(RST) |-> ANALOG_ENABLES == pll_cfg_pkg::ANALOG_RESET
        && PUMP_SETTINGS.pump_down_gain == 7'h0a && PUMP_SETTINGS.offset_down
        && AUX_TRIGGER == pll_cfg_pkg::TRIGGER_RESET)
        else $error("Register reset value wrong.");

    AST_READ_LOAD: assert property (@(posedge CLOCK) disable iff (RST)
        CE && rise && cnt_reg == pll_cfg_pkg::ADDR_DONE - 6'h01
        |=> out_reg == $past(read_word))
        else $error("Readback word not loaded after address.");

    // The divider clock must reach the logic straight out of reset.
    AST_RESET_CLOCKS: assert property (@(posedge CLOCK)
        $fell(RST) |-> ANALOG_ENABLES.divider_clock_to_logic_on)
        else $error("Divider clock enable reset value wrong.");

    // The divide-by-two stage stays off until software turns it on.
    AST_RESET_DIVIDE: assert property (@(posedge CLOCK)
        $fell(RST) |-> !ANALOG_ENABLES.divide_by_two_on)
        else $error("Divide-by-two reset value wrong.");

    // The three block enables in bits 11:9 come out of reset on.
    AST_RESET_BLOCKS: assert property (@(posedge CLOCK)
        $fell(RST) |-> ANALOG_ENABLES.pump_opamp_on && ANALOG_ENABLES.vco_prescaler_bias_on
        && ANALOG_ENABLES.prescaler_clock_on)
        else $error("Block enable reset value wrong.");

    // Up gain starts at ten steps, with no offset current in the up direction.
    AST_RESET_PUMP: assert property (@(posedge CLOCK)
        $fell(RST) |-> PUMP_SETTINGS.pump_up_gain == 7'h0a
        && PUMP_SETTINGS.offset_magnitude == 7'h00 && !PUMP_SETTINGS.offset_up)
        else $error("Pump gain reset value wrong.");

    // A read frame ending must leave every register untouched.
    AST_READ_NO_WRITE: assert property (@(posedge CLOCK) disable iff (RST)
        CE && !sel && sel_prev_reg && rd_flag_reg
        |=> $stable(ANALOG_ENABLES) && $stable(PUMP_SETTINGS) && $stable(AUX_TRIGGER))
        else $error("Read frame changed a register.");

    // Bits past the end of a frame neither count nor shift.
    AST_FRAME_STOP: assert property (@(posedge CLOCK) disable iff (RST)
        CE && rise && cnt_reg == pll_cfg_pkg::FRAME_BITS
        |=> cnt_reg == pll_cfg_pkg::FRAME_BITS && $stable(shift_reg))
        else $error("Bit beyond the frame was taken.");

    // Each readback fall moves the top stored bit to the pad driver.
    AST_SDO_SHIFT: assert property (@(posedge CLOCK) disable iff (RST)
        CE && fall && reading |=> sdo_reg == $past(out_reg[23]))
        else $error("Readback bit not shifted out.");
endmodule : pll_cfg_regs

// ===== verification/tb_top.sv
/*
 * Self-checking bench for the analog-enable, charge-pump and trigger register bank.
 * Assumes the bank is reached only through its serial frame port and that the bench
 * alone drives every input, on the falling edge of CLOCK.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // =========================================================================
    // Signals and design instance
    // =========================================================================
    logic                     clock;
    logic                     rst;
    logic                     ssel;
    logic                     sck;
    logic                     sdi;
    logic                     always_on;
    logic                     rb_sel;
    logic                     lock;
    logic                     ce;
    pll_cfg_pkg::analog_en_s  an;
    pll_cfg_pkg::pump_s       pu;
    logic [23:0]              trig;
    logic                     pad_out;
    logic                     pad_oe;
    logic [23:0]              q;
    logic                     oe_and;
    logic                     oe_or;
    int                       fail_count;
    int                       n_tests;
    int                       cyc;

    pll_cfg_regs dut_u (
        .CLOCK(clock), .RST(rst), .CE(ce), .SERIAL_SELECT(ssel), .SERIAL_CLOCK(sck),
        .SERIAL_DATA_IN(sdi), .PAD_ALWAYS_ON(always_on), .READBACK_SELECT(rb_sel),
        .LOCK_STATE(lock), .ANALOG_ENABLES(an), .PUMP_SETTINGS(pu), .AUX_TRIGGER(trig),
        .LOCK_READBACK_PIN_OUT(pad_out), .LOCK_READBACK_PIN_OE(pad_oe)
    );

    // Free-running 250 MHz clock.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // A hang is cut short here; the frame traffic needs well under this many cycles.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    // =========================================================================
    // Shared tasks
    // =========================================================================
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask : wait_n

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Serial levels last five cycles, above the three the synchroniser needs.
    // Readback bits are taken just before each rise, where the host samples them.
    // Bits past the 31st go out as ones, to probe that the bank ignores them.
    task automatic frame(input logic rd, input logic [5:0] a, input logic [23:0] d,
                         input int nbits);
        logic [30:0] w;
        w = {rd, a, d};
        q = 24'h000000;
        oe_and = 1'b1;
        oe_or = 1'b0;
        ssel = 1'b1;
        wait_n(4);
        for (int i = 0; i < nbits; i++) begin
            sdi = (i < 31) ? w[30-i] : 1'b1;
            sck = 1'b0;
            wait_n(5);
            if (i >= 7 && i < 31) begin
                q[30-i] = pad_out;
                oe_and = oe_and & pad_oe;
                oe_or = oe_or | pad_oe;
            end
            sck = 1'b1;
            wait_n(5);
        end
        sck = 1'b0;
        wait_n(2);
        ssel = 1'b0;
        wait_n(8);
    endtask : frame

    // =========================================================================
    // Scenarios
    // =========================================================================
    task automatic t_reset;
        chk(an, 24'hc1beff);
        chk(24'(an.divider_clock_to_logic_on), 24'h000001);
        chk(24'({an.pump_opamp_on, an.vco_prescaler_bias_on, an.prescaler_clock_on}), 24'h7);
        chk(24'({an.resync_bias, an.rf_buffer_bias}), 24'h00001b);
        chk(24'(an.divide_by_two_on), 24'h000000);
        chk(24'(pu.pump_down_gain), 24'h00000a);
        chk(24'(pu.pump_up_gain), 24'h00000a);
        chk(24'(pu.offset_magnitude), 24'h000000);
        chk(24'(pu.offset_up), 24'h000000);
        chk(24'(pu.offset_down), 24'h000001);
        chk(trig, 24'h002205);
        chk(24'(pad_oe), 24'h000000);
        $display("test reset values done");
    endtask : t_reset

    // The pump word sets high-gain mode while the opamp bit stays on, as software must.
    task automatic t_write_read;
        frame(1'b0, 6'h0a, 24'h001800, 31);
        chk(trig, 24'h001800);
        frame(1'b0, 6'h09, 24'ha5c3e1, 31);
        chk(pu, 24'ha5c3e1);
        frame(1'b1, 6'h09, 24'h000000, 31);
        chk(q, 24'ha5c3e1);
        chk(24'(oe_and), 24'h000001);
        frame(1'b1, 6'h0a, 24'h000000, 31);
        chk(q, 24'h001800);
        $display("test write and readback done");
    endtask : t_write_read

    task automatic t_pad;
        frame(1'b0, 6'h08, 24'he9bedf, 31);
        chk(an, 24'he9bedf);
        chk(24'(an.high_freq_reference), 24'h000001);
        chk(24'(an.divide_by_two_on), 24'h000001);
        always_on = 1'b1;
        frame(1'b1, 6'h08, 24'h000000, 31);
        chk(24'(oe_or), 24'h000000);
        frame(1'b0, 6'h08, 24'hc1beff, 31);
        // Clock enable low freezes the pad even while the lock input moves.
        ce = 1'b0;
        lock = 1'b1;
        wait_n(5);
        chk(24'({pad_oe, pad_out}), 24'h000002);
        ce = 1'b1;
        wait_n(5);
        chk(24'({pad_oe, pad_out}), 24'h000003);
        lock = 1'b0;
        wait_n(5);
        chk(24'({pad_oe, pad_out}), 24'h000002);
        always_on = 1'b0;
        rb_sel = 1'b1;
        frame(1'b1, 6'h09, 24'h000000, 31);
        chk(24'(oe_or), 24'h000000);
        rb_sel = 1'b0;
        $display("test pad control done");
    endtask : t_pad

    // Short, read and unmapped frames must leave every register as it was.
    task automatic t_refuse;
        frame(1'b0, 6'h0a, 24'h00abcd, 30);
        chk(trig, 24'h001800);
        frame(1'b1, 6'h0a, 24'h00abcd, 31);
        chk(trig, 24'h001800);
        frame(1'b0, 6'h0b, 24'h123456, 31);
        chk(an, 24'hc1beff);
        chk(pu, 24'ha5c3e1);
        frame(1'b1, 6'h0b, 24'h000000, 31);
        chk(q, 24'h000000);
        frame(1'b0, 6'h0a, 24'h00abcd, 32);
        chk(trig, 24'h00abcd);
        rst = 1'b1;
        wait_n(2);
        rst = 1'b0;
        wait_n(2);
        chk(trig, 24'h002205);
        chk(pu, 24'h40050a);
        $display("test refusals and second reset done");
    endtask : t_refuse

    // =========================================================================
    // Main sequence and closing report
    // =========================================================================
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    initial begin
        {rst, ssel, sck, sdi, always_on, rb_sel, lock, ce} = 8'h81;
        fail_count = 0;
        n_tests = 0;
        cyc = 0;
        wait_n(5);
        rst = 1'b0;
        wait_n(2);
        t_reset();
        t_write_read();
        t_pad();
        t_refuse();
        stop_test();
    end
endmodule : tb_top
